// ### csbx_pkg.sv
// Package for the compare, skip and branch execution block
package csbx_pkg;

    // ------------------------------------------------------------
    // Status flag bit positions
    // ------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    // ------------------------------------------------------------
    // Widths, reset values and pc steps
    // ------------------------------------------------------------
    localparam int PC_W = 16;
    localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP_TWO = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP_THREE = 16'h0003;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 16'h0000;
    localparam int EXEC_CYCLES = 1;

    // ------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        OP_NONE,
        OP_REG_CMP,
        OP_REG_CMP_C,
        OP_IMM_CMP,
        OP_SKIP_REG_CLR,
        OP_SKIP_REG_SET,
        OP_SKIP_IO_CLR,
        OP_SKIP_IO_SET,
        OP_BR_SET,
        OP_BR_CLR
    } csbx_op_t;

    // ------------------------------------------------------------
    // Request carried from decode
    // ------------------------------------------------------------
    typedef struct packed
    {
        csbx_op_t         op;
        logic [7:0]       dst_val;
        logic [7:0]       src_val;
        logic [7:0]       imm_val;
        logic [7:0]       io_val;
        logic [2:0]       bit_sel;
        logic signed [6:0] offset;
        logic             next_is_long;
    } csbx_req_t;

endpackage

// ### csbx_exec.sv
// Compare, skip and branch execution unit
`timescale 1ns/10ps
module csbx_exec
    import csbx_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Request
    input  wire logic            req_valid,
    input  wire csbx_req_t       req,
    input  wire logic [PC_W-1:0] pc_in,
    // Results
    output logic [PC_W-1:0]      pc_out,
    output logic                 pc_valid,
    output logic [7:0]           status_flags_reg
);

    // ------------------------------------------------------------
    // Flag arithmetic
    // ------------------------------------------------------------
    function automatic logic [7:0] sub_flags(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       cin,
                                             input logic       chain,
                                             input logic [7:0] old);
        logic [7:0] r;
        logic [7:0] f;
        r = a - b - {7'h00, cin};
        f = old;
        f[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        f[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        f[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        f[FLAG_N] = r[7];
        // Carry form keeps zero only while it holds, for multi-byte use
        f[FLAG_Z] = chain ? ((r == 8'h00) & old[FLAG_Z]) : (r == 8'h00);
        f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
        return f;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic       reg_bit = req.dst_val[req.bit_sel];
    wire logic       io_bit = req.io_val[req.bit_sel];
    wire logic       flag_bit = status_flags_reg[req.bit_sel];
    wire logic       cmp_carry = status_flags_reg[FLAG_C];
    wire logic [7:0] flags_reg_cmp = sub_flags(req.dst_val, req.src_val,
                                     1'b0, 1'b0, status_flags_reg);
    wire logic [7:0] flags_reg_cmpc = sub_flags(req.dst_val, req.src_val,
                                      cmp_carry, 1'b1, status_flags_reg);
    wire logic [7:0] flags_imm_cmp = sub_flags(req.dst_val, req.imm_val,
                                     1'b0, 1'b0, status_flags_reg);
    wire logic skip_rc = (req.op == OP_SKIP_REG_CLR) && !reg_bit;
    wire logic skip_rs = (req.op == OP_SKIP_REG_SET) && reg_bit;
    wire logic skip_ic = (req.op == OP_SKIP_IO_CLR) && !io_bit;
    wire logic skip_is = (req.op == OP_SKIP_IO_SET) && io_bit;
    wire logic do_skip = skip_rc | skip_rs | skip_ic | skip_is;
    wire logic br_s = (req.op == OP_BR_SET) && flag_bit;
    wire logic br_c = (req.op == OP_BR_CLR) && !flag_bit;
    wire logic do_branch = br_s | br_c;

    // Skip length depends on the size of the bypassed instruction
    wire logic [PC_W-1:0] skip_step = req.next_is_long ? PC_STEP_THREE
                                                       : PC_STEP_TWO;
    wire logic [PC_W-1:0] br_off = {{(PC_W-7){req.offset[6]}}, req.offset};
    wire logic [PC_W-1:0] next_pc =
        do_branch ? PC_W'(pc_in + br_off + PC_STEP_ONE) :
        do_skip   ? PC_W'(pc_in + skip_step) :
                    PC_W'(pc_in + PC_STEP_ONE);

    logic [7:0] next_flags;
    always_comb
    begin
        case (req.op)
            OP_REG_CMP:   next_flags = flags_reg_cmp;
            OP_REG_CMP_C: next_flags = flags_reg_cmpc;
            OP_IMM_CMP:   next_flags = flags_imm_cmp;
            default:      next_flags = status_flags_reg;
        endcase
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // single cycle update
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_flags_reg <= FLAGS_RST;
            pc_out <= PC_RST;
            pc_valid <= 1'b0;
        end
        else
        begin
            pc_valid <= req_valid;
            if (req_valid)
            begin
                status_flags_reg <= next_flags;
                pc_out <= next_pc;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_imm_cmp;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_IMM_CMP |=>
            status_flags_reg[FLAG_Z] == ($past(req.dst_val)
                                         == $past(req.imm_val))
            && pc_out == $past(pc_in) + PC_STEP_ONE;
    endproperty
    a_imm_cmp: assert property (p_imm_cmp)
        else $error("immediate compare wrong");

    property p_skip_rc;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_SKIP_REG_CLR && !reg_bit
        && !req.next_is_long |=> pc_out == $past(pc_in) + PC_STEP_TWO;
    endproperty
    a_skip_rc: assert property (p_skip_rc)
        else $error("register clear skip wrong");

    property p_skip_rs;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_SKIP_REG_SET && reg_bit
        && req.next_is_long |=> pc_out == $past(pc_in) + PC_STEP_THREE;
    endproperty
    a_skip_rs: assert property (p_skip_rs)
        else $error("register set skip wrong");

    property p_skip_ic;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_SKIP_IO_CLR && io_bit
        |=> pc_out == $past(pc_in) + PC_STEP_ONE;
    endproperty
    a_skip_ic: assert property (p_skip_ic)
        else $error("io clear no-skip wrong");

    property p_skip_is;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_SKIP_IO_SET && io_bit
        && !req.next_is_long |=>
            pc_valid && pc_out == $past(pc_in) + PC_STEP_TWO;
    endproperty
    a_skip_is: assert property (p_skip_is)
        else $error("io set skip wrong");

    property p_br_s;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_BR_SET && flag_bit |=>
            pc_out == PC_W'($past(pc_in) + $past(br_off) + PC_STEP_ONE);
    endproperty
    a_br_s: assert property (p_br_s)
        else $error("branch on set wrong");

    property p_br_c;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_BR_CLR && flag_bit |=>
            pc_out == $past(pc_in) + PC_STEP_ONE;
    endproperty
    a_br_c: assert property (p_br_c)
        else $error("branch on clear fall-through wrong");

    property p_reg_cmp;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_REG_CMP |=>
            status_flags_reg[FLAG_C] == ($past(req.dst_val)
                                         < $past(req.src_val));
    endproperty
    a_reg_cmp: assert property (p_reg_cmp)
        else $error("register compare carry wrong");

    // Answer comes exactly one edge after the request
    property p_answer;
        @(posedge clk) disable iff (rst)
        1'b1 |=> pc_valid == $past(req_valid);
    endproperty
    a_answer: assert property (p_answer)
        else $error("answer not one cycle after request");

    property p_skip_rc_long;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_SKIP_REG_CLR && !reg_bit
        && req.next_is_long |=> pc_out == $past(pc_in) + PC_STEP_THREE;
    endproperty
    a_skip_rc_long: assert property (p_skip_rc_long)
        else $error("register clear long skip wrong");

    property p_skip_ic_take;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_SKIP_IO_CLR && !io_bit
        && !req.next_is_long |=> pc_out == $past(pc_in) + PC_STEP_TWO;
    endproperty
    a_skip_ic_take: assert property (p_skip_ic_take)
        else $error("io clear skip wrong");

    // Offset sign is widened here without the decode wire
    property p_br_c_taken;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_BR_CLR && !flag_bit |=>
            pc_out == PC_W'($past(pc_in) + PC_W'($past(req.offset))
                            + PC_STEP_ONE);
    endproperty
    a_br_c_taken: assert property (p_br_c_taken)
        else $error("branch on clear target wrong");

    // Borrow out of a nine-bit difference
    property p_reg_cmpc;
        @(posedge clk) disable iff (rst)
        req_valid && req.op == OP_REG_CMP_C |=>
            status_flags_reg[FLAG_C] == ({1'b0, $past(req.dst_val)}
                < ({1'b0, $past(req.src_val)}
                   + {8'h00, $past(status_flags_reg[FLAG_C])}));
    endproperty
    a_reg_cmpc: assert property (p_reg_cmpc)
        else $error("carry compare borrow wrong");

endmodule

// ### tb_csbx_exec.sv
// Self-checking testbench for the compare, skip and branch unit
`timescale 1ns/10ps
module tb_csbx_exec
    import csbx_pkg::*;
;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            req_valid = 1'b0;
    csbx_req_t       req = '0;
    logic [PC_W-1:0] pc_in = '0;
    logic [PC_W-1:0] pc_out;
    logic            pc_valid;
    logic [7:0]      flags;
    int              errors = 0;
    int              tests_run = 0;
    logic            pv = 1'b0;
    logic [PC_W-1:0] epc = PC_RST;
    logic [PC_W-1:0] p = 16'h0100;
    logic [7:0]      ef = FLAGS_RST;

    csbx_exec u_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req(req), .pc_in(pc_in), .pc_out(pc_out), .pc_valid(pc_valid),
        .status_flags_reg(flags));

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // Reference model and checking
    // ------------------------------------------------------------
    function automatic logic [7:0] sub_flags(input logic [7:0] a, b,
        input logic cin, chain, input logic [7:0] old);
        logic [8:0] d;
        logic       v;
        d = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        v = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
        // Carry compare only keeps zero, for multi-byte chains
        return {old[7:6], (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]),
            d[7] ^ v, v, d[7], (d[7:0] == 8'h00) & (~chain | old[1]), d[8]};
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Drives one request and checks the previous one; requests pipeline
    task automatic step(input logic v, input csbx_op_t op,
        input logic [7:0] a, b, input logic [2:0] s,
        input logic [6:0] k, input logic lng);
        logic [7:0]      nf;
        logic [7:0]      alt;
        logic [PC_W-1:0] np;
        logic [PC_W-1:0] sk;
        alt = (op == OP_IMM_CMP) ? ~b : b;
        @(posedge clk);
        req_valid <= v;
        req <= '{op, a, alt, ~alt, b, s, k, lng};
        pc_in <= p;
        @(negedge clk);
        chk("pc_valid", {15'h0000, pc_valid}, {15'h0000, pv});
        chk("pc_out", pc_out, epc);
        chk("flags", {8'h00, flags}, {8'h00, ef});
        pv = v;
        if (v)
        begin
            nf = ef;
            np = p + PC_STEP_ONE;
            sk = lng ? PC_STEP_THREE : PC_STEP_TWO;
            case (op)
                OP_REG_CMP: nf = sub_flags(a, b, 1'b0, 1'b0, ef);
                OP_REG_CMP_C: nf = sub_flags(a, b, ef[FLAG_C], 1'b1, ef);
                OP_IMM_CMP: nf = sub_flags(a, b, 1'b0, 1'b0, ef);
                OP_SKIP_REG_CLR: if (!a[s]) np = p + sk;
                OP_SKIP_REG_SET: if (a[s]) np = p + sk;
                OP_SKIP_IO_CLR: if (!b[s]) np = p + sk;
                OP_SKIP_IO_SET: if (b[s]) np = p + sk;
                OP_BR_SET: if (ef[s]) np = p + 16'h0001 + {{9{k[6]}}, k};
                OP_BR_CLR: if (!ef[s]) np = p + 16'h0001 + {{9{k[6]}}, k};
                default: np = p + PC_STEP_ONE;
            endcase
            epc = np;
            ef = nf;
            p = np;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_compare;
        step(1'b1, OP_IMM_CMP, 8'h10, 8'h10, 3'h0, 7'h00, 1'b0);
        step(1'b1, OP_IMM_CMP, 8'h00, 8'h01, 3'h0, 7'h00, 1'b0);
        step(1'b1, OP_IMM_CMP, 8'h80, 8'h01, 3'h0, 7'h00, 1'b0);
        step(1'b1, OP_REG_CMP, 8'h34, 8'h35, 3'h0, 7'h00, 1'b0);
        step(1'b1, OP_REG_CMP_C, 8'h01, 8'h00, 3'h0, 7'h00, 1'b0);
        step(1'b1, OP_REG_CMP_C, 8'h12, 8'h12, 3'h0, 7'h00, 1'b0);
        step(1'b1, OP_REG_CMP, 8'h12, 8'h12, 3'h0, 7'h00, 1'b0);
        step(1'b1, OP_REG_CMP_C, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
        step(1'b1, OP_REG_CMP_C, 8'h01, 8'h00, 3'h0, 7'h00, 1'b0);
    endtask

    // Register and I/O values are complements to catch a swapped source
    task automatic t_skip;
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 4; j++)
                step(1'b1, csbx_op_t'(OP_SKIP_REG_CLR + i),
                    j[0] ? 8'h08 : 8'hF7, j[0] ? 8'hF7 : 8'h08,
                    3'h3, 7'h00, j[1]);
        step(1'b0, OP_NONE, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
    endtask

    task automatic t_branch;
        for (int f = 0; f < 2; f++)
        begin
            step(1'b1, OP_IMM_CMP, 8'h00, f ? 8'h01 : 8'h00, 3'h0, 7'h00,
                1'b0);
            for (int s = 0; s < 8; s++)
            begin
                step(1'b1, OP_BR_SET, 8'h00, 8'h00, 3'(s), 7'h05,
                    1'b0);
                step(1'b1, OP_BR_CLR, 8'h00, 8'h00, 3'(s), 7'h7D,
                    1'b0);
            end
        end
        step(1'b1, OP_NONE, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
        step(1'b0, OP_NONE, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
    endtask

    // Mid-run reset must clear pc and flags left by earlier work
    task automatic t_reset;
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("rst pc_valid", {15'h0000, pc_valid}, 16'h0000);
        chk("rst pc_out", pc_out, PC_RST);
        chk("rst flags", {8'h00, flags}, {8'h00, FLAGS_RST});
        @(posedge clk);
        rst <= 1'b0;
        pv = 1'b0;
        epc = PC_RST;
        ef = FLAGS_RST;
        // Cleared carry must make the first branch take
        step(1'b1, OP_BR_CLR, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0);
        step(1'b0, OP_NONE, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic results;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Run takes about 80 cycles; generous margin
    initial
    begin
        repeat (2000) @(posedge clk);
        errors++;
        results();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_compare();
        t_skip();
        t_branch();
        t_reset();
        results();
    end
endmodule
